// ---- src/dlb_regs.vh ----
// Register map, field positions, reset values and codes of the dual leader blend block
`ifndef DLB_REGS_VH
`define DLB_REGS_VH

`define DLB_ADR_CTRL 8'h00
`define DLB_ADR_L1_NUM 8'h04
`define DLB_ADR_L1_DEN 8'h08
`define DLB_ADR_L2_NUM 8'h0C
`define DLB_ADR_L2_DEN 8'h10
`define DLB_ADR_ACC 8'h14
`define DLB_ADR_DEC 8'h18
`define DLB_ADR_JERK 8'h1C
`define DLB_ADR_STATUS 8'h20
`define DLB_ADR_IRQ_STAT 8'h24
`define DLB_ADR_IRQ_MASK 8'h28
`define DLB_ADR_FOLLOW 8'h2C
`define DLB_ADR_FAULT 8'h30

`define DLB_CTRL_COMBINE 0
`define DLB_CTRL_SRC1 1
`define DLB_CTRL_SRC2 2
`define DLB_CTRL_HANDOFF 3

`define DLB_IRQ_LOCKED 0
`define DLB_IRQ_PREEMPT 1
`define DLB_IRQ_FAULT 2

`define DLB_RST_CTRL 4'h0
`define DLB_RST_RATIO 16'h0001
`define DLB_RST_LIMIT 16'h0001

`define DLB_ERR_NONE 16'h0000
`define DLB_ERR_DEN_ZERO 16'h0001
`define DLB_ERR_LIMIT_ZERO 16'h0002

`endif

// ---- src/dlb_combiner.v ----
// Dual leader blend: follower axis driven by the scaled sum or difference of two leaders
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`include "dlb_regs.vh"

module dlb_combiner #(
    parameter POS_W = 32,
    parameter RAT_W = 16
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire start_i,
    input wire preempt_i,
    input wire [POS_W-1:0] leader1_cmd_pos_i,
    input wire [POS_W-1:0] leader1_act_pos_i,
    input wire [POS_W-1:0] leader2_cmd_pos_i,
    input wire [POS_W-1:0] leader2_act_pos_i,
    output reg [POS_W-1:0] follower_pos_o,
    output reg busy_o,
    output reg active_o,
    output reg locked_flag_o,
    output reg preempted_flag_o,
    output reg error_o,
    output reg [15:0] fault_code_o,
    output reg irq_o
);

    localparam ST_IDLE = 5'b00001;
    localparam ST_RAMP = 5'b00010;
    localparam ST_SYNC = 5'b00100;
    localparam ST_ABORT = 5'b01000;
    localparam ST_FAULT = 5'b10000;
    localparam PW = 2 * POS_W;

    // Byte-lane merge for Wishbone writes
    function [31:0] lane_merge;
        input [31:0] old;
        input [31:0] wdat;
        input [3:0] sel;
        integer k;
        begin
            lane_merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (sel[k]) begin
                    lane_merge[8*k +: 8] = wdat[8*k +: 8];
                end
            end
        end
    endfunction

    // Byte-lane merge for the ratio and limit registers, cut to their own width
    function [RAT_W-1:0] lane_rat;
        input [RAT_W-1:0] old;
        input [31:0] wdat;
        input [3:0] sel;
        reg [31:0] m;
        begin
            m = lane_merge({{(32-RAT_W){1'b0}}, old}, wdat, sel);
            lane_rat = m[RAT_W-1:0];
        end
    endfunction

    // Scale one change: returns {quotient, remainder}; remainder carries forward
    function [PW-1:0] scale;
        input signed [POS_W-1:0] d;
        input signed [RAT_W-1:0] num;
        input signed [RAT_W-1:0] den;
        input signed [POS_W-1:0] rem;
        reg signed [PW:0] t;
        reg signed [PW:0] q;
        reg signed [PW:0] r;
        begin
            t = d * num + rem;
            if (den == 0) begin
                q = 0;
                r = 0;
            end else begin
                q = t / den;
                r = t - q * den;
            end
            scale = {q[POS_W-1:0], r[POS_W-1:0]};
        end
    endfunction

    function [POS_W-1:0] mag;
        input signed [POS_W-1:0] v;
        begin
            mag = v[POS_W-1] ? -v : v;
        end
    endfunction

    // Software-facing registers
    reg [3:0] ctrl_r;
    reg [RAT_W-1:0] l1_num_r, l1_den_r, l2_num_r, l2_den_r;
    reg [RAT_W-1:0] acc_r, dec_r, jerk_r;
    reg [2:0] irq_stat_r;
    reg [2:0] irq_mask_r;

    // Values captured at the start edge
    reg [3:0] cap_ctrl_r;
    reg signed [RAT_W-1:0] c1_num_r, c1_den_r, c2_num_r, c2_den_r;
    reg [RAT_W-1:0] c_acc_r, c_dec_r, c_jerk_r;

    // Start comes from another domain: two flops, then a third for the edge
    reg start_s1_r, start_s2_r, start_s3_r;
    reg [4:0] state_r;
    reg [4:0] state_nxt;
    reg [POS_W-1:0] prev1_r, prev2_r;
    reg signed [POS_W-1:0] rem1_r, rem2_r;
    reg signed [POS_W-1:0] target_r, vel_r;
    reg [POS_W-1:0] step_lim_r;

    wire start_edge = start_s2_r & ~start_s3_r;
    wire [POS_W-1:0] cur1 = cap_ctrl_r[`DLB_CTRL_SRC1] ? leader1_act_pos_i : leader1_cmd_pos_i;
    wire [POS_W-1:0] cur2 = cap_ctrl_r[`DLB_CTRL_SRC2] ? leader2_act_pos_i : leader2_cmd_pos_i;
    wire [POS_W-1:0] sel1 = ctrl_r[`DLB_CTRL_SRC1] ? leader1_act_pos_i : leader1_cmd_pos_i;
    wire [POS_W-1:0] sel2 = ctrl_r[`DLB_CTRL_SRC2] ? leader2_act_pos_i : leader2_cmd_pos_i;
    wire signed [POS_W-1:0] d1 = cur1 - prev1_r;
    wire signed [POS_W-1:0] d2 = cur2 - prev2_r;
    wire [PW-1:0] s1 = scale(d1, c1_num_r, c1_den_r, rem1_r);
    wire [PW-1:0] s2 = scale(d2, c2_num_r, c2_den_r, rem2_r);
    wire signed [POS_W-1:0] q1 = s1[PW-1:POS_W];
    wire signed [POS_W-1:0] q2 = s2[PW-1:POS_W];
    wire signed [POS_W-1:0] comb = cap_ctrl_r[`DLB_CTRL_COMBINE] ? q1 - q2 : q1 + q2;
    wire signed [POS_W-1:0] tgt_nxt = target_r + comb;
    wire signed [POS_W-1:0] gap = target_r - $signed(follower_pos_o);
    wire [15:0] fault_chk = (l1_den_r == 0 || l2_den_r == 0) ? `DLB_ERR_DEN_ZERO :
        (acc_r == 0 || dec_r == 0 || jerk_r == 0) ? `DLB_ERR_LIMIT_ZERO : `DLB_ERR_NONE;

    // Ramp toward the moving target with jerk-limited velocity steps
    // The gap is closed by an eighth per cycle, or by one per cycle below 8, so the approach slows and
    // velocity and gap reach the lock point together instead of overshooting
    reg signed [POS_W-1:0] corr, want, dv, step;
    reg [POS_W-1:0] lim, lim_nxt;
    always @* begin
        corr = 0;
        want = 0;
        dv = 0;
        step = 0;
        lim = 0;
        lim_nxt = 0;
        if (mag(gap) >= 8) begin
            corr = gap >>> 3;
        end else if (gap != 0) begin
            corr = gap[POS_W-1] ? -1 : 1;
        end
        want = comb + corr;
        dv = want - vel_r;
        lim = (mag(want) >= mag(vel_r)) ? {{(POS_W-RAT_W){1'b0}}, c_acc_r} :
            {{(POS_W-RAT_W){1'b0}}, c_dec_r};
        lim_nxt = (step_lim_r + c_jerk_r >= lim) ? lim : step_lim_r + c_jerk_r;
        if (dv > $signed(lim_nxt)) begin
            step = lim_nxt;
        end else if (dv < -$signed(lim_nxt)) begin
            step = -lim_nxt;
        end else begin
            step = dv;
        end
    end

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RAMP: begin
                if (preempt_i) begin
                    state_nxt = ST_ABORT;
                end else if (gap == 0 && vel_r == comb) begin
                    state_nxt = ST_SYNC;
                end
            end
            ST_SYNC: begin
                if (preempt_i) begin
                    state_nxt = ST_ABORT;
                end
            end
            ST_ABORT: begin
                if (!start_s2_r) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = state_r;
        endcase
        // A new edge restarts from any state, finished or not
        if (start_edge) begin
            state_nxt = (fault_chk != `DLB_ERR_NONE) ? ST_FAULT : ST_RAMP;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            start_s1_r <= 1'b0;
            start_s2_r <= 1'b0;
            start_s3_r <= 1'b0;
            state_r <= ST_IDLE;
            cap_ctrl_r <= `DLB_RST_CTRL;
            c1_num_r <= `DLB_RST_RATIO;
            c1_den_r <= `DLB_RST_RATIO;
            c2_num_r <= `DLB_RST_RATIO;
            c2_den_r <= `DLB_RST_RATIO;
            c_acc_r <= `DLB_RST_LIMIT;
            c_dec_r <= `DLB_RST_LIMIT;
            c_jerk_r <= `DLB_RST_LIMIT;
            prev1_r <= 0;
            prev2_r <= 0;
            rem1_r <= 0;
            rem2_r <= 0;
            target_r <= 0;
            vel_r <= 0;
            step_lim_r <= 0;
            follower_pos_o <= 0;
            busy_o <= 1'b0;
            active_o <= 1'b0;
            locked_flag_o <= 1'b0;
            preempted_flag_o <= 1'b0;
            error_o <= 1'b0;
            fault_code_o <= `DLB_ERR_NONE;
        end else begin
            start_s1_r <= start_i;
            start_s2_r <= start_s1_r;
            start_s3_r <= start_s2_r;
            state_r <= state_nxt;
            // Flags follow the next state; the start level is looked at only in ST_ABORT,
            // so dropping start in mid-run leaves them alone
            busy_o <= (state_nxt == ST_RAMP) || (state_nxt == ST_SYNC);
            active_o <= (state_nxt == ST_RAMP) || (state_nxt == ST_SYNC);
            locked_flag_o <= (state_nxt == ST_SYNC);
            preempted_flag_o <= (state_nxt == ST_ABORT);
            error_o <= (state_nxt == ST_FAULT);
            if (start_edge) begin
                // capture everything and restart tracking from here
                cap_ctrl_r <= ctrl_r;
                c1_num_r <= l1_num_r;
                c1_den_r <= l1_den_r;
                c2_num_r <= l2_num_r;
                c2_den_r <= l2_den_r;
                c_acc_r <= acc_r;
                c_dec_r <= dec_r;
                c_jerk_r <= jerk_r;
                prev1_r <= sel1;
                prev2_r <= sel2;
                rem1_r <= 0;
                rem2_r <= 0;
                target_r <= follower_pos_o;
                vel_r <= 0;
                step_lim_r <= 0;
                fault_code_o <= fault_chk;
            end else if (state_r == ST_RAMP || state_r == ST_SYNC) begin
                prev1_r <= cur1;
                prev2_r <= cur2;
                rem1_r <= s1[POS_W-1:0];
                rem2_r <= s2[POS_W-1:0];
                target_r <= tgt_nxt;
                if (state_r == ST_SYNC || state_nxt == ST_SYNC) begin
                    // Locked: follower takes exactly the combined change
                    vel_r <= comb;
                    follower_pos_o <= follower_pos_o + comb;
                end else begin
                    vel_r <= vel_r + step;
                    step_lim_r <= lim_nxt;
                    follower_pos_o <= follower_pos_o + vel_r + step;
                end
            end
        end
    end

    // Wishbone classic slave: one wait state, ack one cycle after the strobe
    // No request is taken in a cycle in which ack is high, so a master that holds stb sees ack on every second cycle
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_req & wb_we_i;
    wire [2:0] irq_set = {(state_nxt == ST_FAULT) & (state_r != ST_FAULT),
        (state_nxt == ST_ABORT) & (state_r != ST_ABORT),
        (state_nxt == ST_SYNC) & (state_r != ST_SYNC)};
    wire [31:0] ctrl_w = lane_merge({28'h000_0000, ctrl_r}, wb_dat_i, wb_sel_i);
    wire [31:0] irq_w = lane_merge(32'h0000_0000, wb_dat_i, wb_sel_i);

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl_r <= `DLB_RST_CTRL;
            l1_num_r <= `DLB_RST_RATIO;
            l1_den_r <= `DLB_RST_RATIO;
            l2_num_r <= `DLB_RST_RATIO;
            l2_den_r <= `DLB_RST_RATIO;
            acc_r <= `DLB_RST_LIMIT;
            dec_r <= `DLB_RST_LIMIT;
            jerk_r <= `DLB_RST_LIMIT;
            irq_stat_r <= 3'b000;
            irq_mask_r <= 3'b000;
            irq_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_wr) begin
                case (wb_adr_i)
                    `DLB_ADR_CTRL: ctrl_r <= ctrl_w[3:0];
                    `DLB_ADR_L1_NUM: l1_num_r <= lane_rat(l1_num_r, wb_dat_i, wb_sel_i);
                    `DLB_ADR_L1_DEN: l1_den_r <= lane_rat(l1_den_r, wb_dat_i, wb_sel_i);
                    `DLB_ADR_L2_NUM: l2_num_r <= lane_rat(l2_num_r, wb_dat_i, wb_sel_i);
                    `DLB_ADR_L2_DEN: l2_den_r <= lane_rat(l2_den_r, wb_dat_i, wb_sel_i);
                    `DLB_ADR_ACC: acc_r <= lane_rat(acc_r, wb_dat_i, wb_sel_i);
                    `DLB_ADR_DEC: dec_r <= lane_rat(dec_r, wb_dat_i, wb_sel_i);
                    `DLB_ADR_JERK: jerk_r <= lane_rat(jerk_r, wb_dat_i, wb_sel_i);
                    `DLB_ADR_IRQ_MASK: irq_mask_r <= irq_w[2:0];
                    default: ;
                endcase
            end else if (wb_req) begin
                case (wb_adr_i)
                    `DLB_ADR_CTRL: wb_dat_o <= {28'h000_0000, ctrl_r};
                    `DLB_ADR_L1_NUM: wb_dat_o <= {16'h0000, l1_num_r};
                    `DLB_ADR_L1_DEN: wb_dat_o <= {16'h0000, l1_den_r};
                    `DLB_ADR_L2_NUM: wb_dat_o <= {16'h0000, l2_num_r};
                    `DLB_ADR_L2_DEN: wb_dat_o <= {16'h0000, l2_den_r};
                    `DLB_ADR_ACC: wb_dat_o <= {16'h0000, acc_r};
                    `DLB_ADR_DEC: wb_dat_o <= {16'h0000, dec_r};
                    `DLB_ADR_JERK: wb_dat_o <= {16'h0000, jerk_r};
                    `DLB_ADR_STATUS: wb_dat_o <= {20'h0_0000, cap_ctrl_r, 3'b000,
                        error_o, preempted_flag_o, locked_flag_o, active_o, busy_o};
                    `DLB_ADR_IRQ_STAT: wb_dat_o <= {29'h0000_0000, irq_stat_r};
                    `DLB_ADR_IRQ_MASK: wb_dat_o <= {29'h0000_0000, irq_mask_r};
                    `DLB_ADR_FOLLOW: wb_dat_o <= follower_pos_o;
                    `DLB_ADR_FAULT: wb_dat_o <= {16'h0000, fault_code_o};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
            // Set wins over a simultaneous write-one clear
            if (wb_wr && wb_adr_i == `DLB_ADR_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~irq_w[2:0]) | irq_set;
            end else begin
                irq_stat_r <= irq_stat_r | irq_set;
            end
            irq_o <= |(((irq_stat_r & ~((wb_wr && wb_adr_i == `DLB_ADR_IRQ_STAT) ?
                irq_w[2:0] : 3'b000)) | irq_set) & irq_mask_r);
        end
    end

endmodule // dlb_combiner

// ---- test/dlb_combiner_asserts.sv ----
// Port-level checks for the dual leader blend block
`timescale 1ns/1ps
module dlb_combiner_asserts #(
    parameter POS_W = 32,
    parameter RAT_W = 16
) (
    input wire clk_i,
    input wire rst_i,
    input wire start_i,
    input wire preempt_i,
    input wire busy_o,
    input wire active_o,
    input wire locked_flag_o,
    input wire preempted_flag_o,
    input wire error_o,
    input wire [15:0] fault_code_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    busy_eq_active_a: assert property (busy_o == active_o)
        else $error("busy and active disagree");
    start_raises_busy_a: assert property (
        $rose(start_i) ##1 start_i ##1 start_i |=> busy_o || error_o)
        else $error("no busy or error three edges after start");
    lock_keeps_busy_a: assert property (locked_flag_o |-> busy_o && active_o)
        else $error("in sync without busy and active");
    preempt_drops_a: assert property (
        preempt_i && busy_o |=> preempted_flag_o && !busy_o && !active_o && !locked_flag_o)
        else $error("takeover did not drop the run");
    preempt_holds_a: assert property (
        start_i [*3] ##0 preempted_flag_o |=> preempted_flag_o)
        else $error("preempted cleared while start high");
    preempt_clears_a: assert property (
        preempted_flag_o && !start_i |-> ##[1:5] !preempted_flag_o)
        else $error("preempted did not clear after start low");
    start_fall_ignored_a: assert property (
        busy_o && !preempt_i && $fell(start_i) |=> busy_o [*3])
        else $error("falling start stopped the run");
    fault_code_set_a: assert property (
        error_o |-> fault_code_o == 16'h0001 || fault_code_o == 16'h0002)
        else $error("error without a fault code");
endmodule // dlb_combiner_asserts

bind dlb_combiner dlb_combiner_asserts #(.POS_W(POS_W), .RAT_W(RAT_W)) dlb_combiner_asserts_i (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .preempt_i(preempt_i), .busy_o(busy_o),
    .active_o(active_o), .locked_flag_o(locked_flag_o), .preempted_flag_o(preempted_flag_o),
    .error_o(error_o), .fault_code_o(fault_code_o));

// ---- test/dlb_combiner_test.sv ----
// Self-checking bench for the dual leader blend block
`timescale 1ns/1ps
`include "dlb_regs.vh"
module dlb_combiner_test;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, start_i = 1'b0, preempt_i = 1'b0;
    reg [7:0] wb_adr_i = 8'h00;
    reg [3:0] wb_sel_i = 4'hf;
    reg [31:0] wb_dat_i = 32'h0000_0000, l1c = 32'h0000_0000, l1a = 32'h0000_0000;
    reg [31:0] l2c = 32'h0000_0000, l2a = 32'h0000_0000, q, exp_pos, d1, d2;
    wire [31:0] wb_dat_o, follower_pos_o;
    wire [15:0] fault_code_o;
    wire wb_ack_o, busy_o, active_o, locked_flag_o, preempted_flag_o, error_o, irq_o;
    integer bad_count = 0, n_checks = 0, i, n;
    reg [31:0] l1_run = 32'h0000_0000, l1_rate = 32'h0000_0000;
    always #2.5 clk_i = ~clk_i;
    // Leader one can also run at a steady rate, for starts with leader one in motion
    always @(posedge clk_i) begin
        l1_run <= l1_run + l1_rate;
    end

    dlb_combiner dlb_combiner_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .start_i(start_i),
        .preempt_i(preempt_i), .leader1_cmd_pos_i(l1c + l1_run), .leader1_act_pos_i(l1a),
        .leader2_cmd_pos_i(l2c), .leader2_act_pos_i(l2a), .follower_pos_o(follower_pos_o),
        .busy_o(busy_o), .active_o(active_o), .locked_flag_o(locked_flag_o),
        .preempted_flag_o(preempted_flag_o), .error_o(error_o), .fault_code_o(fault_code_o),
        .irq_o(irq_o));

    task stop_test;
        begin
            $display("Checks made %0d, mismatches %0d", n_checks, bad_count);
            if (bad_count == 0 && n_checks > 0) begin
                $display("All checks passed");
            end else begin
                $display("Checks failed");
            end
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("BAD at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // One classic cycle; ack is seen at the edge where it is high, then released
    task wb(input we, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk_i);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= we;
            wb_sel_i <= 4'hf;
            wb_adr_i <= a;
            wb_dat_i <= d;
            n = 0;
            @(posedge clk_i);
            while (wb_ack_o !== 1'b1 && n < 50) begin
                n = n + 1;
                @(posedge clk_i);
            end
            q = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            if (n >= 50) begin
                chk(32'h0000_0000, 32'h0000_0001);
                stop_test;
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        wb(1'b1, a, d);
    endtask
    task rc(input [7:0] a, input [31:0] e);
        begin
            wb(1'b0, a, 32'h0000_0000);
            chk(q, e);
        end
    endtask
    function hit(input [1:0] s);
        case (s)
            2'd0: hit = locked_flag_o === 1'b1;
            2'd1: hit = busy_o === 1'b1 || error_o === 1'b1;
            2'd2: hit = preempted_flag_o === 1'b0;
            default: hit = follower_pos_o === exp_pos;
        endcase
    endfunction
    task wait_on(input [1:0] s);
        begin
            n = 0;
            while (!hit(s) && n < 3000) begin
                n = n + 1;
                @(posedge clk_i);
            end
            if (n >= 3000) begin
                chk({30'h0000_0000, s}, 32'h0000_00ff);
                stop_test;
            end
        end
    endtask
    // Start low long enough for the synchroniser, then a fresh edge
    task kick;
        begin
            @(posedge clk_i);
            start_i <= 1'b0;
            repeat (4) @(posedge clk_i);
            start_i <= 1'b1;
            repeat (5) @(posedge clk_i);
            wait_on(2'd1);
        end
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(`DLB_ADR_CTRL, 32'h0000_0000);
        rc(`DLB_ADR_L1_NUM, 32'h0000_0001);
        rc(`DLB_ADR_ACC, 32'h0000_0001);
        rc(`DLB_ADR_IRQ_MASK, 32'h0000_0000);
        rc(8'h3C, 32'h0000_0000);
        $display("Reset value test done");
        wr(`DLB_ADR_L1_NUM, 32'h0000_0003);
        wr(`DLB_ADR_L1_DEN, 32'h0000_0002);
        wr(`DLB_ADR_L2_NUM, 32'h0000_0005);
        wr(`DLB_ADR_L2_DEN, 32'h0000_0003);
        wr(`DLB_ADR_ACC, 32'h0000_0040);
        wr(`DLB_ADR_DEC, 32'h0000_0040);
        wr(`DLB_ADR_JERK, 32'h0000_0040);
        exp_pos = 32'h0000_0000;
        // Each pass after the first restarts with new mode and sources while the last run is live
        for (i = 0; i < 8; i = i + 1) begin
            wr(`DLB_ADR_CTRL, i);
            kick;
            wait_on(2'd0);
            chk(busy_o & active_o, 32'h0000_0001);
            d1 = i[1] ? 32'd30 : 32'd60;
            d2 = i[2] ? 32'd10 : 32'd20;
            exp_pos = i[0] ? exp_pos + d1 - d2 : exp_pos + d1 + d2;
            @(posedge clk_i);
            l1c <= l1c + 32'd40;
            l1a <= l1a + 32'd20;
            l2c <= l2c + 32'd12;
            l2a <= l2a + 32'd6;
            wait_on(2'd3);
            repeat (20) @(posedge clk_i);
            chk(follower_pos_o, exp_pos);
            $display("Combine pass %0d done", i);
        end
        wr(`DLB_ADR_CTRL, 32'h0000_0000);
        wr(`DLB_ADR_L1_NUM, 32'h0000_0001);
        wr(`DLB_ADR_L1_DEN, 32'h0000_0003);
        kick;
        wait_on(2'd0);
        for (i = 0; i < 10; i = i + 1) begin
            @(posedge clk_i);
            l1c <= l1c + 32'd1;
        end
        exp_pos = exp_pos + 32'd3;
        wait_on(2'd3);
        repeat (20) @(posedge clk_i);
        chk(follower_pos_o, exp_pos);
        $display("Remainder carry test done");
        // Restart with leader one already running: the follower must ramp, then lock
        wr(`DLB_ADR_CTRL, 32'h0000_0008);
        @(posedge clk_i);
        l1_rate <= 32'h0000_012C;
        kick;
        chk(locked_flag_o, 32'h0000_0000);
        wait_on(2'd0);
        @(posedge clk_i);
        exp_pos = follower_pos_o + 32'h0000_03E8;
        repeat (10) @(posedge clk_i);
        chk(follower_pos_o, exp_pos);
        rc(`DLB_ADR_STATUS, 32'h0000_0807);
        l1_rate <= 32'h0000_0000;
        $display("Ramp test done");
        @(posedge clk_i);
        preempt_i <= 1'b1;
        @(posedge clk_i);
        preempt_i <= 1'b0;
        @(posedge clk_i);
        chk({preempted_flag_o, busy_o, active_o, locked_flag_o}, 32'h0000_0008);
        repeat (10) @(posedge clk_i);
        chk(preempted_flag_o, 32'h0000_0001);
        start_i <= 1'b0;
        wait_on(2'd2);
        chk(busy_o, 32'h0000_0000);
        rc(`DLB_ADR_IRQ_STAT, 32'h0000_0003);
        chk(irq_o, 32'h0000_0000);
        wr(`DLB_ADR_IRQ_MASK, 32'h0000_0002);
        repeat (2) @(posedge clk_i);
        chk(irq_o, 32'h0000_0001);
        wr(`DLB_ADR_IRQ_STAT, 32'h0000_0002);
        repeat (2) @(posedge clk_i);
        chk(irq_o, 32'h0000_0000);
        rc(`DLB_ADR_IRQ_STAT, 32'h0000_0001);
        wr(`DLB_ADR_IRQ_MASK, 32'h0000_0007);
        $display("Takeover and interrupt test done");
        wr(`DLB_ADR_L1_DEN, 32'h0000_0000);
        kick;
        chk({error_o, fault_code_o}, 32'h0001_0001);
        wr(`DLB_ADR_L1_DEN, 32'h0000_0001);
        wr(`DLB_ADR_ACC, 32'h0000_0000);
        kick;
        chk({error_o, fault_code_o}, 32'h0001_0002);
        rc(`DLB_ADR_FAULT, 32'h0000_0002);
        rc(`DLB_ADR_IRQ_STAT, 32'h0000_0005);
        chk(irq_o, 32'h0000_0001);
        $display("Fault test done");
        stop_test;
    end
endmodule // dlb_combiner_test
